// >>> hw/sfc_pkg.sv
// Package: opcodes, frame descriptors and timing for the serial flash host controller
package sfc_pkg;
  localparam logic [7:0] OP_RST_EN = 8'h66;
  localparam logic [7:0] OP_RST_MEM = 8'h99;
  localparam logic [7:0] OP_RD_ID = 8'h9f;
  localparam logic [7:0] OP_RD_ID_ALT = 8'h9e;
  localparam logic [7:0] OP_MIO_ID = 8'haf;
  localparam logic [7:0] OP_DISC = 8'h5a;
  localparam logic [7:0] OP_RD = 8'h03;
  localparam logic [7:0] OP_FRD = 8'h0b;
  localparam logic [7:0] OP_FRD_DO = 8'h3b;
  localparam logic [7:0] OP_FRD_DIO = 8'hbb;
  localparam logic [7:0] OP_FRD_QO = 8'h6b;
  localparam logic [7:0] OP_FRD_QIO = 8'heb;
  localparam logic [7:0] OP_DFRD = 8'h0d;
  localparam logic [7:0] OP_DFRD_DO = 8'h3d;
  localparam logic [7:0] OP_DFRD_DIO = 8'hbd;
  localparam logic [7:0] OP_DFRD_QO = 8'h6d;
  localparam logic [7:0] OP_DFRD_QIO = 8'hed;
  localparam logic [7:0] OP_QIO_WRD = 8'he7;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RD_SR = 8'h05;
  localparam logic [7:0] OP_RD_FSR = 8'h70;
  localparam logic [7:0] OP_RD_NVCR = 8'hb5;
  localparam logic [7:0] OP_RD_VCR = 8'h85;
  localparam logic [7:0] OP_RD_EVCR = 8'h65;
  localparam logic [7:0] OP_RD_GPR = 8'h96;
  localparam logic [7:0] OP_WR_SR = 8'h01;
  localparam logic [7:0] OP_WR_NVCR = 8'hb1;
  localparam logic [7:0] OP_WR_VCR = 8'h81;
  localparam logic [7:0] OP_WR_EVCR = 8'h61;
  localparam logic [7:0] OP_CLR_FSR = 8'h50;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_PP_DI = 8'ha2;
  localparam logic [7:0] OP_PP_DIX = 8'hd2;
  localparam logic [7:0] OP_PP_QI = 8'h32;
  localparam logic [7:0] OP_PP_QIX = 8'h38;
  localparam logic [7:0] OP_ER_32K = 8'h52;
  localparam logic [7:0] OP_ER_4K = 8'h20;
  localparam logic [7:0] OP_ER_SEC = 8'hd8;

  localparam logic [1:0] PROT_EXT = 2'h0;
  localparam logic [1:0] PROT_DUAL = 2'h1;
  localparam logic [1:0] PROT_QUAD = 2'h2;

  localparam logic [2:0] LN1 = 3'h1;
  localparam logic [2:0] LN2 = 3'h2;
  localparam logic [2:0] LN4 = 3'h4;
  localparam logic [2:0] LN0 = 3'h0;

  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [4:0] DUM_0 = 5'h00;
  localparam logic [4:0] DUM_4 = 5'h04;
  localparam logic [4:0] DUM_6 = 5'h06;
  localparam logic [4:0] DUM_8 = 5'h08;
  localparam logic [4:0] DUM_10 = 5'h0a;

  // Serial clock: half period in system cycles (125 MHz / 8 = 15.625 MHz in dummy and read phases, 125 MHz / 12 while driving)
  localparam int SCK_HALF_NS = 32;
  localparam int SYS_CLK_NS = 8;
  localparam logic [3:0] SCK_HALF_CYC = 4'((SCK_HALF_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

  localparam int FIFO_DEPTH = 8;
  localparam int DATA_W = 8;

  // Frame descriptor for one command
  typedef struct packed {
    logic valid;
    logic [2:0] cmd_lanes;
    logic [2:0] addr_lanes;
    logic [2:0] data_lanes;
    logic [1:0] addr_bytes;
    logic [4:0] dummy;
    logic dtr;
    logic data_in;
    logic data_out;
  } sfc_frame_t;

  // Host request
  typedef struct packed {
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [8:0] len;
    logic [4:0] dummy_ovr;
    logic use_ovr;
  } sfc_req_t;
endpackage

// >>> hw/sfc_fifo.sv
// Parameterised valid/ready FIFO for data bytes
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i, // System clock
  input wire logic srst_i, // Sync reset
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  input wire logic in_valid_i, // Write valid
  output logic in_ready_o, // Not full
  output logic [WIDTH-1:0] out_data_o, // Read data
  output logic out_valid_o, // Not empty
  input wire logic out_ready_i // Read accept
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic push;
  logic pop;

  assign in_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid_o = wp_r != rp_r;
  assign out_data_o = mem_r[rp_r[AW-1:0]];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_r[wp_r[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
      begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop)
      begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule // sfc_fifo

// >>> hw/sfc_host.sv
// Host controller framing serial flash commands on the data lanes
module sfc_host
  import sfc_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic srst_i, // Sync reset, active high
  input wire logic [1:0] prot_i, // Active protocol
  input wire sfc_req_t req_i, // Command request
  input wire logic req_valid_i, // Request strobe
  output logic req_ready_o, // Idle, request taken
  output logic req_err_o, // Pulse: opcode refused
  output logic done_o, // Pulse: frame finished
  input wire logic [7:0] wr_data_i, // Program data
  input wire logic wr_valid_i, // Program data valid
  output logic wr_ready_o, // Program data ready
  output logic [7:0] rd_data_o, // Read data
  output logic rd_valid_o, // Read data valid
  input wire logic rd_ready_i, // Read data ready
  output logic sck_o, // Serial clock
  output logic cs_n_o, // Chip select, active low
  output logic [3:0] serial_data_lanes_o, // Lane drive
  output logic [3:0] serial_data_lanes_oe_o, // Lane enable
  input wire logic [3:0] serial_data_lanes_i // Lane sense
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001, ST_CMD = 7'b0000010, ST_ADDR = 7'b0000100,
    ST_DUM = 7'b0001000, ST_WR = 7'b0010000, ST_RD = 7'b0100000,
    ST_END = 7'b1000000
  } sfc_state_t;

  function automatic sfc_frame_t decode(input logic [7:0] op, input logic [1:0] p);
    sfc_frame_t f;
    logic [2:0] pl;
    f = '0;
    pl = (p == PROT_QUAD) ? LN4 : (p == PROT_DUAL) ? LN2 : LN1;
    f.cmd_lanes = pl;
    f.addr_lanes = pl;
    f.data_lanes = pl;
    f.valid = 1'b1;
    case (op)
      OP_RST_EN, OP_RST_MEM, OP_WREN, OP_WRDI, OP_CLR_FSR: ;
      OP_RD_ID, OP_RD_ID_ALT:
      begin
        f.valid = (p == PROT_EXT);
        f.data_in = 1'b1;
      end
      OP_MIO_ID, OP_RD_SR, OP_RD_FSR, OP_RD_NVCR, OP_RD_VCR, OP_RD_EVCR: f.data_in = 1'b1;
      OP_RD_GPR:
      begin
        f.data_in = 1'b1;
        f.dummy = DUM_8;
      end
      OP_WR_SR, OP_WR_NVCR, OP_WR_VCR, OP_WR_EVCR: f.data_out = 1'b1;
      OP_DISC:
      begin
        f.addr_bytes = ADDR_BYTES;
        f.dummy = DUM_8;
        f.data_in = 1'b1;
      end
      OP_RD:
      begin
        f.valid = (p == PROT_EXT);
        f.addr_bytes = ADDR_BYTES;
        f.data_in = 1'b1;
      end
      OP_FRD, OP_DFRD:
      begin
        f.addr_bytes = ADDR_BYTES;
        f.data_in = 1'b1;
        f.dtr = (op == OP_DFRD);
        f.dummy = (op == OP_DFRD) ? ((p == PROT_QUAD) ? DUM_8 : DUM_6)
                                  : ((p == PROT_QUAD) ? DUM_10 : DUM_8);
      end
      OP_FRD_DO, OP_FRD_DIO, OP_DFRD_DO, OP_DFRD_DIO, OP_PP_DI, OP_PP_DIX:
      begin
        f.valid = (p != PROT_QUAD);
        f.addr_bytes = ADDR_BYTES;
        f.data_lanes = LN2;
        f.addr_lanes = (op == OP_FRD_DIO || op == OP_DFRD_DIO || op == OP_PP_DIX
                        || p == PROT_DUAL) ? LN2 : LN1;
        f.dtr = (op == OP_DFRD_DO || op == OP_DFRD_DIO);
        f.dummy = (op == OP_PP_DI || op == OP_PP_DIX) ? DUM_0 : f.dtr ? DUM_6 : DUM_8;
        f.data_in = !(op == OP_PP_DI || op == OP_PP_DIX);
        f.data_out = (op == OP_PP_DI || op == OP_PP_DIX);
      end
      OP_FRD_QO, OP_FRD_QIO, OP_DFRD_QO, OP_DFRD_QIO, OP_QIO_WRD, OP_PP_QI, OP_PP_QIX:
      begin
        f.valid = (p != PROT_DUAL);
        f.addr_bytes = ADDR_BYTES;
        f.data_lanes = LN4;
        f.addr_lanes = (op == OP_FRD_QO || op == OP_DFRD_QO || op == OP_PP_QI)
                       && p == PROT_EXT ? LN1 : LN4;
        f.dtr = (op == OP_DFRD_QO || op == OP_DFRD_QIO);
        f.data_out = (op == OP_PP_QI || op == OP_PP_QIX);
        f.data_in = !f.data_out;
        case (op)
          OP_FRD_QO: f.dummy = (p == PROT_QUAD) ? DUM_10 : DUM_8;
          OP_FRD_QIO: f.dummy = DUM_10;
          OP_DFRD_QO: f.dummy = (p == PROT_QUAD) ? DUM_8 : DUM_6;
          OP_DFRD_QIO: f.dummy = DUM_8;
          OP_QIO_WRD: f.dummy = DUM_4;
          default: f.dummy = DUM_0;
        endcase
      end
      OP_PP, OP_ER_32K, OP_ER_4K, OP_ER_SEC:
      begin
        f.addr_bytes = ADDR_BYTES;
        f.data_out = (op == OP_PP);
      end
      default: f.valid = 1'b0;
    endcase
    return f;
  endfunction

  sfc_state_t state_r;
  sfc_frame_t frm_r;
  sfc_frame_t frm_nxt;
  logic [31:0] sh_r;
  logic [5:0] bits_r;
  logic [4:0] dum_r;
  logic [8:0] len_r;
  logic [3:0] div_r;
  logic tick;
  logic [3:0] sin_m_r;
  logic [3:0] sin_r;
  logic [7:0] rx_r;
  logic [3:0] rxn_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic rx_push_r;
  logic [2:0] ln;
  logic wr_pop;
  logic drv_r;
  logic [31:0] sh_src;
  logic [5:0] bits_src;

  assign frm_nxt = decode(req_i.opcode, prot_i);
  assign ln = (state_r == ST_CMD) ? frm_r.cmd_lanes
            : (state_r == ST_ADDR) ? frm_r.addr_lanes : frm_r.data_lanes;
  assign tick = (div_r == SCK_HALF_CYC - 1'b1);
  assign wr_ready_o = wr_pop;
  assign wr_pop = (state_r == ST_WR) && tick && !sck_o && !drv_r && bits_r == '0
                  && len_r != '0;
  // Next byte enters straight onto the lanes
  assign sh_src = wr_pop ? {wr_data_i, 24'h0} : sh_r;
  assign bits_src = wr_pop ? 6'd8 : bits_r;

  // Lane input synchroniser
  always_ff @(posedge sys_clk_i)
  begin
    sin_m_r <= serial_data_lanes_i;
    sin_r <= sin_m_r;
  end

  // Serial clock divider; runs only inside a frame
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i || state_r == ST_IDLE)
    begin
      div_r <= '0;
    end
    else if (tick)
    begin
      div_r <= '0;
    end
    else if (!(state_r == ST_RD && !fifo_in_ready))
    begin
      div_r <= div_r + 1'b1;
    end
  end

  // Frame sequencer
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      state_r <= ST_IDLE;
      frm_r <= '0;
      sh_r <= '0;
      bits_r <= '0;
      dum_r <= '0;
      len_r <= '0;
      sck_o <= 1'b0;
      cs_n_o <= 1'b1;
      serial_data_lanes_o <= '0;
      serial_data_lanes_oe_o <= '0;
      req_ready_o <= 1'b0;
      req_err_o <= 1'b0;
      done_o <= 1'b0;
      rx_r <= '0;
      rxn_r <= '0;
      rx_push_r <= 1'b0;
      drv_r <= 1'b0;
    end
    else
    begin
      req_err_o <= 1'b0;
      done_o <= 1'b0;
      rx_push_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o)
          begin
            req_ready_o <= 1'b0;
            if (!frm_nxt.valid)
            begin
              req_err_o <= 1'b1;
            end
            else
            begin
              frm_r <= frm_nxt;
              if (req_i.use_ovr && frm_nxt.dummy != DUM_0 && req_i.opcode != OP_DISC)
              begin
                frm_r.dummy <= req_i.dummy_ovr;
              end
              sh_r <= {req_i.opcode, req_i.addr};
              bits_r <= 6'd8;
              len_r <= req_i.len;
              rxn_r <= '0;
              cs_n_o <= 1'b0;
              state_r <= ST_CMD;
            end
          end
        end
        ST_CMD, ST_ADDR, ST_WR:
        begin
          if (tick && sck_o)
          begin
            sck_o <= 1'b0;
          end
          else if (tick && !drv_r)
          begin
            // Drive in the low half, one half period before the rise
            drv_r <= 1'b1;
            serial_data_lanes_oe_o <= (ln == LN4) ? 4'hf : (ln == LN2) ? 4'h3 : 4'h1;
            serial_data_lanes_o <= (ln == LN4) ? sh_src[31:28] : (ln == LN2)
                                   ? {2'h0, sh_src[31:30]} : {3'h0, sh_src[31]};
            sh_r <= (ln == LN4) ? {sh_src[27:0], 4'h0} : (ln == LN2)
                    ? {sh_src[29:0], 2'h0} : {sh_src[30:0], 1'b0};
            bits_r <= bits_src - 6'(ln);
            if (wr_pop)
            begin
              len_r <= len_r - 1'b1;
            end
          end
          else if (tick)
          begin
            drv_r <= 1'b0;
            sck_o <= 1'b1;
            if (bits_r == '0)
            begin
              if (state_r == ST_CMD && frm_r.addr_bytes != '0)
              begin
                state_r <= ST_ADDR;
                bits_r <= 6'(8 * ADDR_BYTES);
              end
              else if (state_r != ST_WR && frm_r.dummy != DUM_0)
              begin
                state_r <= ST_DUM;
                dum_r <= frm_r.dummy;
              end
              else if (state_r != ST_WR && frm_r.data_in)
              begin
                state_r <= ST_RD;
              end
              else if (frm_r.data_out && len_r != '0 && wr_valid_i)
              begin
                state_r <= ST_WR;
              end
              else
              begin
                state_r <= ST_END;
              end
            end
          end
        end
        ST_DUM:
        begin
          serial_data_lanes_oe_o <= '0;
          sck_o <= tick ? !sck_o : sck_o;
          // Count rises, so the device's first bit lands before the next rise
          if (tick && !sck_o)
          begin
            dum_r <= dum_r - 1'b1;
            if (dum_r == 5'h01)
            begin
              state_r <= frm_r.data_in ? ST_RD : ST_END;
            end
          end
        end
        ST_RD:
        begin
          serial_data_lanes_oe_o <= '0;
          if (tick && fifo_in_ready)
          begin
            sck_o <= !sck_o;
            // Sample on rising edge (DTR also samples on falling)
            if (!sck_o || frm_r.dtr)
            begin
              rx_r <= (frm_r.data_lanes == LN4) ? {rx_r[3:0], sin_r}
                    : (frm_r.data_lanes == LN2) ? {rx_r[5:0], sin_r[1:0]}
                    : {rx_r[6:0], sin_r[1]};
              if (rxn_r + 4'(frm_r.data_lanes) >= 4'h8)
              begin
                rxn_r <= '0;
                rx_push_r <= 1'b1;
                len_r <= len_r - 1'b1;
                if (len_r == 9'h001)
                begin
                  state_r <= ST_END;
                end
              end
              else
              begin
                rxn_r <= rxn_r + 4'(frm_r.data_lanes);
              end
            end
          end
        end
        ST_END:
        begin
          // Finish the last high half before deselecting
          if (tick || !sck_o)
          begin
            sck_o <= 1'b0;
            cs_n_o <= 1'b1;
            serial_data_lanes_oe_o <= '0;
            done_o <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  sfc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .in_data_i(rx_r),
    .in_valid_i(rx_push_r),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(rd_ready_i && !rd_valid_o)
  );

  // Registered read output stage
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= '0;
    end
    else if (rd_valid_o)
    begin
      rd_valid_o <= 1'b0;
    end
    else if (fifo_out_valid && rd_ready_i)
    begin
      rd_valid_o <= 1'b1;
      rd_data_o <= fifo_out_data;
    end
  end
endmodule // sfc_host

// >>> verif/sfc_host_props.sv
// Port checker for the serial flash host controller
module sfc_host_props
  import sfc_pkg::*;
(
  input wire logic sys_clk_i, // System clock
  input wire logic srst_i, // Sync reset
  input wire logic [1:0] prot_i, // Protocol
  input wire logic req_valid_i, // Request strobe
  input wire logic req_ready_o, // Idle
  input wire logic req_err_o, // Refusal pulse
  input wire logic done_o, // Frame end pulse
  input wire logic rd_valid_o, // Read valid
  input wire logic rd_ready_i, // Read ready
  input wire logic sck_o, // Serial clock
  input wire logic cs_n_o, // Select
  input wire logic [3:0] serial_data_lanes_o, // Lane drive
  input wire logic [3:0] serial_data_lanes_oe_o // Lane enable
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [3:0] cmd_oe;
  assign cmd_oe = (prot_i == PROT_QUAD) ? 4'hf : (prot_i == PROT_DUAL) ? 4'h3 : 4'h1;
  reset_idle_a: assert property (disable iff (1'b0) srst_i |=> cs_n_o && !sck_o
    && serial_data_lanes_oe_o == 4'h0 && !req_ready_o)
    else $error("outputs not idle after reset");
  take_frame_a: assert property (req_valid_i && req_ready_o |=> req_err_o || !cs_n_o)
    else $error("taken request neither refused nor selected");
  err_quiet_a: assert property (req_err_o |-> cs_n_o && !sck_o && serial_data_lanes_oe_o == 4'h0)
    else $error("refused opcode drove the link");
  busy_ready_a: assert property (!cs_n_o |-> !req_ready_o)
    else $error("ready while selected");
  done_pulse_a: assert property ($rose(cs_n_o) |-> ##[0:1] done_o)
    else $error("no done after deselect");
  done_ready_a: assert property (done_o |-> ##[1:3] req_ready_o)
    else $error("not ready after done");
  cmd_lanes_a: assert property ($fell(cs_n_o) |-> ##[0:4] serial_data_lanes_oe_o == cmd_oe)
    else $error("opcode lane count wrong for protocol");
  sck_high_a: assert property ($rose(sck_o) |-> sck_o [*4])
    else $error("serial clock high phase short");
  sck_low_a: assert property ($fell(sck_o) |-> (!sck_o) [*4])
    else $error("serial clock low phase short");
  lane_hold_a: assert property (sck_o && $past(sck_o) && serial_data_lanes_oe_o != 4'h0
    |-> $stable(serial_data_lanes_o))
    else $error("lane drive changed while clock high");
  sck_idle_a: assert property (cs_n_o && $past(cs_n_o) |-> !sck_o)
    else $error("clock moved while deselected");
  rd_hold_a: assert property (rd_valid_o |-> rd_ready_i)
    else $error("read byte offered without ready");
endmodule // sfc_host_props

// >>> verif/sfc_flash_model.sv
// Behavioural serial flash device facing the host controller
module sfc_flash_model
  import sfc_pkg::*;
(
  input wire logic sck_i, // Serial clock
  input wire logic cs_n_i, // Select, active low
  input wire logic [1:0] prot_i, // Active protocol
  input wire logic [3:0] lanes_i, // Resolved lane levels
  output logic [3:0] lanes_o, // Device drive
  output logic [3:0] lanes_oe_o // Device enable
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] op_r;
  logic [7:0] sh_r;
  logic [7:0] fsr_r = 8'h81;
  logic [23:0] addr_r;
  logic [3:0] cfg_dum_r = 4'h0;
  logic ab;
  int t, cl, al, dl, dum, kind, ta, td, nb;
  int n_frames = 0;
  initial
  begin
    for (int k = 0; k < 256; k++)
      mem[k] = 8'(k) ^ 8'h5a;
    lanes_oe_o = 4'h0;
    lanes_o = 4'h0;
  end
  function automatic logic [3:0] take(int w);
    return (w == 1) ? {3'h0, lanes_i[0]} : (w == 2) ? {2'h0, lanes_i[1:0]} : lanes_i;
  endfunction
  always @(negedge cs_n_i)
  begin
    t = 0;
    kind = 0;
    nb = 0;
    n_frames++;
    cl = (prot_i == PROT_QUAD) ? 4 : (prot_i == PROT_DUAL) ? 2 : 1;
  end
  always @(posedge cs_n_i)
  begin
    lanes_oe_o = 4'h0;
    if (op_r == OP_CLR_FSR && t == 8 / cl)
      fsr_r = 8'h00;
  end
  always @(posedge sck_i)
    if (!cs_n_i)
    begin
      t++;
      if (t <= 8 / cl)
        op_r = (op_r << cl) | 8'(take(cl));
      if (t == 8 / cl)
      begin
        al = cl;
        dl = cl;
        ab = !(op_r inside {OP_MIO_ID, OP_RD_FSR, OP_RD_GPR, OP_WR_VCR});
        dum = (op_r inside {OP_DISC, OP_FRD, OP_FRD_DO, OP_FRD_DIO, OP_FRD_QO, OP_RD_GPR}) ? 8 : 0;
        if (op_r == OP_FRD_QIO || (prot_i == PROT_QUAD && op_r inside {OP_FRD_QO, OP_FRD}))
          dum = 10;
        if (op_r inside {OP_FRD_DIO, OP_PP_DIX})
          al = (cl > 2) ? cl : 2;
        if (op_r inside {OP_FRD_QIO, OP_PP_QIX})
          al = 4;
        if (op_r inside {OP_FRD_DO, OP_FRD_DIO, OP_PP_DI, OP_PP_DIX})
          dl = (cl > 2) ? cl : 2;
        if (op_r inside {OP_FRD_QO, OP_FRD_QIO, OP_PP_QI, OP_PP_QIX})
          dl = 4;
        if (op_r inside {OP_PP, OP_PP_DI, OP_PP_DIX, OP_PP_QI, OP_PP_QIX, OP_WR_VCR})
          kind = 2;
        else if (op_r inside {OP_MIO_ID, OP_DISC, OP_RD, OP_FRD, OP_FRD_DO, OP_FRD_DIO,
                              OP_FRD_QO, OP_FRD_QIO, OP_RD_FSR, OP_RD_GPR})
          kind = 1;
        if (cfg_dum_r != 4'h0 && dum != 0 && op_r != OP_DISC)
          dum = cfg_dum_r;
        ta = 8 / cl + (ab ? 24 / al : 0);
        td = ta + dum;
      end
      else if (t > 8 / cl && t <= ta)
        addr_r = (addr_r << al) | 24'(take(al));
      else if (t > td && kind == 2)
      begin
        sh_r = (sh_r << dl) | 8'(take(dl));
        if ((t - td) % (8 / dl) == 0)
        begin
          if (op_r == OP_WR_VCR)
            cfg_dum_r = sh_r[7:4];
          else
            mem[8'(addr_r + 24'(nb))] = sh_r;
          nb++;
        end
      end
    end
  always @(negedge sck_i)
    if (!cs_n_i && kind == 1 && t >= td)
    begin
      if ((t - td) % (8 / dl) == 0)
      begin
        // Identification bytes are arbitrary
        sh_r = (op_r == OP_MIO_ID) ? 8'hc0 + 8'(nb) : (op_r == OP_RD_FSR) ? fsr_r
             : (op_r == OP_RD_GPR) ? 8'h3c + 8'(nb) : mem[8'(addr_r + 24'(nb))];
        nb++;
      end
      lanes_oe_o = (dl == 1) ? 4'h2 : (dl == 2) ? 4'h3 : 4'hf;
      lanes_o = (dl == 1) ? {2'h0, sh_r[7], 1'b0} : (dl == 2) ? {2'h0, sh_r[7:6]} : sh_r[7:4];
      sh_r = sh_r << dl;
    end
endmodule // sfc_flash_model

// >>> verif/serial_flash_command_decoder_test.sv
// Testbench of the serial flash host controller against a device model
`define CHK(a, b, m) \
  begin \
    n_checks++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %0t %s got %h exp %h", $time, m, a, b); \
    end \
  end
bind sfc_host sfc_host_props chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .prot_i(prot_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_err_o(req_err_o),
  .done_o(done_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .sck_o(sck_o),
  .cs_n_o(cs_n_o), .serial_data_lanes_o(serial_data_lanes_o),
  .serial_data_lanes_oe_o(serial_data_lanes_oe_o));
module serial_flash_command_decoder_test
  import sfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [1:0] prot_i = PROT_EXT;
  sfc_req_t req_i = '0;
  logic req_valid_i = 1'b0;
  logic req_ready_o, req_err_o, done_o, wr_ready_o, rd_valid_o, sck_o, cs_n_o;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_valid_i = 1'b0;
  logic rd_ready_i = 1'b1;
  logic [7:0] rd_data_o;
  logic [3:0] host_do, host_oe, dev_do, dev_oe, lanes_w;
  logic [3:0] last_w = 4'h0;
  logic [7:0] wbuf [256] = '{default: 8'h00};
  logic [7:0] rbuf [$];
  logic err_seen;
  int n_mismatch = 0;
  int n_checks = 0;
  int stall = 0;
  initial forever #4 sys_clk_i = ~sys_clk_i;
  always_comb
    for (int k = 0; k < 4; k++)
      lanes_w[k] = host_oe[k] ? host_do[k] : dev_oe[k] ? dev_do[k] : ~last_w[k];
  always @(posedge sys_clk_i)
    last_w <= lanes_w;
  sfc_host dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .prot_i(prot_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_err_o(req_err_o),
    .done_o(done_o), .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .sck_o(sck_o),
    .cs_n_o(cs_n_o), .serial_data_lanes_o(host_do), .serial_data_lanes_oe_o(host_oe),
    .serial_data_lanes_i(lanes_w));
  sfc_flash_model dev (.sck_i(sck_o), .cs_n_i(cs_n_o), .prot_i(prot_i), .lanes_i(lanes_w),
    .lanes_o(dev_do), .lanes_oe_o(dev_oe));
  task automatic end_of_test();
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  function automatic logic [7:0] pat(logic [23:0] a, int k);
    return 8'(a + 24'(k)) ^ 8'h5a;
  endfunction
  // One command frame; collects read bytes, feeds write bytes from wbuf
  task automatic run(input logic [1:0] p, input logic [7:0] op, input logic [23:0] a,
    input logic [8:0] n, input logic ov, input logic [4:0] d);
    int i;
    int post;
    logic taken;
    i = 0;
    post = 0;
    taken = 1'b0;
    err_seen = 1'b0;
    rbuf.delete();
    prot_i = p;
    req_i = '{op, a, n, d, ov};
    req_valid_i = 1'b1;
    for (int w = 0; w < 30000; w++)
    begin
      wr_data_i = wbuf[i];
      wr_valid_i = (i < n);
      rd_ready_i = (w >= stall);
      @(posedge sys_clk_i);
      if (req_ready_o === 1'b1 && req_valid_i)
        taken = 1'b1;
      if (rd_valid_o === 1'b1 && rd_ready_i)
        rbuf.push_back(rd_data_o);
      if (wr_ready_o === 1'b1 && wr_valid_i)
        i++;
      if (req_err_o === 1'b1)
        err_seen = 1'b1;
      if (post > 0 || done_o === 1'b1 || req_err_o === 1'b1)
        post++;
      #1;
      if (taken)
        req_valid_i = 1'b0;
      if (post > 20)
        return;
    end
    n_mismatch++;
    $display("MISMATCH %0t frame did not finish", $time);
    end_of_test();
  endtask
  task automatic s_id();
    run(PROT_EXT, OP_MIO_ID, 24'h0, 20, 1'b0, 5'h0);
    `CHK(rbuf.size(), 20, "id count")
    for (int k = 0; k < 20; k++)
      `CHK(rbuf[k], 8'hc0 + 8'(k), "id byte")
    run(PROT_QUAD, OP_MIO_ID, 24'h0, 3, 1'b0, 5'h0);
    `CHK(rbuf[2], 8'hc2, "quad id byte")
  endtask
  task automatic s_flags();
    int f;
    run(PROT_EXT, OP_RD_FSR, 24'h0, 3, 1'b0, 5'h0);
    for (int k = 0; k < 3; k++)
      `CHK(rbuf[k], 8'h81, "flag byte")
    f = dev.n_frames;
    run(PROT_QUAD, OP_CLR_FSR, 24'h0, 1, 1'b0, 5'h0);
    run(PROT_DUAL, OP_WREN, 24'h0, 1, 1'b0, 5'h0);
    `CHK(dev.n_frames, f + 2, "opcode only frames")
    run(PROT_DUAL, OP_RD_FSR, 24'h0, 2, 1'b0, 5'h0);
    `CHK(rbuf[1], 8'h00, "flag cleared")
  endtask
  task automatic s_reads();
    logic [1:0] rp [14] = '{0, 1, 0, 1, 0, 2, 0, 2, 0, 1, 2, 0, 2, 0};
    logic [7:0] ro [14] = '{OP_FRD_DO, OP_FRD_DO, OP_FRD_DIO, OP_FRD_DIO, OP_FRD_QO,
      OP_FRD_QO, OP_FRD_QIO, OP_FRD_QIO, OP_DISC, OP_DISC, OP_DISC, OP_FRD, OP_FRD, OP_RD};
    for (int i = 0; i < 14; i++)
    begin
      run(rp[i], ro[i], 24'h10 + 24'(8 * i), 4, 1'b0, 5'h0);
      `CHK(rbuf.size(), 4, "read count")
      for (int k = 0; k < 4; k++)
        `CHK(rbuf[k], pat(24'h10 + 24'(8 * i), k), "read byte")
    end
    for (int p = 0; p < 3; p++)
    begin
      run(2'(p), OP_RD_GPR, 24'h0, 2, 1'b0, 5'h0);
      `CHK(rbuf[1], 8'h3d, "register byte")
    end
  endtask
  task automatic s_program();
    logic [1:0] pp [9] = '{0, 1, 0, 1, 0, 2, 0, 2, 0};
    logic [7:0] po [9] = '{OP_PP_DI, OP_PP_DI, OP_PP_DIX, OP_PP_DIX, OP_PP_QI, OP_PP_QI,
      OP_PP_QIX, OP_PP_QIX, OP_PP};
    for (int i = 0; i < 9; i++)
    begin
      for (int k = 0; k < 4; k++)
        wbuf[k] = 8'(16 * i + k) ^ 8'ha0;
      run(pp[i], po[i], 24'h80 + 24'(8 * i), 4, 1'b0, 5'h0);
      run(pp[i], OP_FRD, 24'h80 + 24'(8 * i), 4, 1'b0, 5'h0);
      for (int k = 0; k < 4; k++)
        `CHK(rbuf[k], wbuf[k], "programmed byte")
    end
  endtask
  task automatic s_refuse();
    int f;
    logic [1:0] fp [4] = '{2, 1, 0, 1};
    logic [7:0] fo [4] = '{OP_FRD_DO, OP_FRD_QO, 8'hff, OP_RD};
    for (int i = 0; i < 4; i++)
    begin
      f = dev.n_frames;
      run(fp[i], fo[i], 24'h0, 1, 1'b0, 5'h0);
      `CHK(err_seen, 1'b1, "opcode not refused")
      `CHK(dev.n_frames, f, "refused opcode selected device")
    end
  endtask
  task automatic s_stall();
    stall = 400;
    run(PROT_EXT, OP_FRD_QIO, 24'h30, 20, 1'b0, 5'h0);
    stall = 0;
    `CHK(rbuf.size(), 20, "stalled read count")
    for (int k = 0; k < 20; k++)
      `CHK(rbuf[k], pat(24'h30, k), "stalled read byte")
  endtask
  task automatic s_override();
    wbuf[0] = 8'h60;
    run(PROT_EXT, OP_WR_VCR, 24'h0, 1, 1'b0, 5'h0);
    run(PROT_EXT, OP_FRD_QIO, 24'h40, 4, 1'b1, 5'h06);
    for (int k = 0; k < 4; k++)
      `CHK(rbuf[k], pat(24'h40, k), "configured dummy read")
    run(PROT_QUAD, OP_DISC, 24'h48, 4, 1'b1, 5'h06);
    for (int k = 0; k < 4; k++)
      `CHK(rbuf[k], pat(24'h48, k), "discovery fixed dummy")
  endtask
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    #1;
    srst_i = 1'b0;
    s_id();
    s_flags();
    s_reads();
    s_program();
    s_refuse();
    s_stall();
    s_override();
    end_of_test();
  end
endmodule // serial_flash_command_decoder_test
